//--- bench/acc_top_tb.sv
// bench: drives the conversion control through its register and memory ports
`timescale 1ns/1ps
module acc_top_tb import acc_pkg::*; ;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    localparam logic [11:0] TARGET = 12'hA5C;
    logic        clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, port1_wr = 1'b0;
    logic        irq_vector_ack = 1'b0, ale_in = 1'b0, live = 1'b0, dma_p = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, port1_wdata = 8'h00;
    logic [7:0]  acq_cycles = 8'h02, conv_div = 8'h03, sfr_rdata, port1_analog_mode;
    logic [3:0]  mux_channel;
    logic        track, result_valid, mem_rd, mem_wr, ale_out;
    logic [11:0] cap_dac, result;
    logic [15:0] mem_addr, mem_wdata, dma_base_addr = 16'h0100;
    wire  [15:0] mem_rdata;
    logic [15:0] wr_log [$];
    int          err_total = 0, compares = 0, k;
    // ideal comparator: trial above the held input
    wire         comparator_hi = (cap_dac > TARGET);

    acc_top dut (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port1_wdata(port1_wdata),
        .port1_wr(port1_wr), .port1_analog_mode(port1_analog_mode),
        .irq_vector_ack(irq_vector_ack), .acq_cycles(acq_cycles), .conv_div(conv_div),
        .mux_channel(mux_channel), .track(track), .cap_dac(cap_dac),
        .comparator_hi(comparator_hi), .result(result), .result_valid(result_valid),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .dma_base_addr(dma_base_addr), .ale_in(ale_in),
        .ale_out(ale_out));

    always #10 clk = ~clk;

    // ------------------------------------------------------------
    // memory holding the identifier list: 1, 2, then the end code
    // ------------------------------------------------------------
    // read data is taken in the strobe cycle; no strobe returns channel 0
    assign mem_rdata = (mem_rd !== 1'b1) ? 16'h0000 : {(mem_addr == dma_base_addr) ? 4'h1 :
        (mem_addr == dma_base_addr + 16'h2) ? 4'h2 : ACC_CH_STOP, 12'h000};

    always @(posedge clk) begin
        ale_in <= #1 ~ale_in;
        if (mem_wr === 1'b1) begin
            wr_log.push_back(mem_wdata);
        end
    end

    // strobe passes delayed by one, held low only while the sequence runs
    always @(posedge clk) begin
        #5;
        if (live && sfr_rdata[ACC_DMA_BIT] === dma_p) begin
            chk("ale_out", sfr_rdata[ACC_DMA_BIT] ? 16'h0 : {15'h0, ~ale_in}, {15'h0, ale_out});
        end
        dma_p = sfr_rdata[ACC_DMA_BIT];
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
    endtask : sfr_write

    task automatic ack_pulse;
        @(posedge clk);
        #1;
        irq_vector_ack = 1'b1;
        @(posedge clk);
        #1;
        irq_vector_ack = 1'b0;
    endtask : ack_pulse

    // bounded wait for one result, then the flag a cycle later
    task automatic wait_result(input logic [3:0] ch);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (result_valid !== 1'b1 && n < 3000);
        chk("result_valid", 16'h1, {15'h0, result_valid});
        chk("result", {4'h0, TARGET}, {4'h0, result});
        chk("track", 16'h0, {15'h0, track});
        chk("mux_channel", {12'h0, ch}, {12'h0, mux_channel});
        @(posedge clk);
        #1;
        chk("done", 16'h1, {15'h0, sfr_rdata[ACC_DONE_BIT]});
    endtask : wait_result

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("ctrl reset", {8'h0, ACC_CTRL_RESET}, {8'h0, sfr_rdata});
        chk("port1 reset", {8'h0, ACC_PORT1_RESET}, {8'h0, port1_analog_mode});
        live = 1'b1;
        port1_wdata = 8'hF0;
        port1_wr = 1'b1;
        @(posedge clk);
        #1 port1_wr = 1'b0;
        chk("port1 mode", 16'h00F0, {8'h0, port1_analog_mode});
        sfr_write(8'hD0, 8'h10);
        chk("ctrl unmapped", 16'h0, {8'h0, sfr_rdata});
        // every defined code, one single conversion each
        for (int c = 0; c <= 12; c++) begin
            acq_cycles = (c == 8) ? ACC_TEMP_ACQ_CYC : 8'h02;
            sfr_write(ACC_CTRL_ADDR, {4'h0, 4'(c)});
            repeat (4) @(posedge clk);
            sfr_write(ACC_CTRL_ADDR, {4'h1, 4'(c)});
            chk("track", 16'h1, {15'h0, track});
            wait_result(4'(c));
            chk("single", 16'h0, {15'h0, sfr_rdata[ACC_SINGLE_BIT]});
            ack_pulse();
            chk("done ack", 16'h0, {15'h0, sfr_rdata[ACC_DONE_BIT]});
        end
        // continuous run: flag again after a software clear
        sfr_write(ACC_CTRL_ADDR, 8'h25);
        wait_result(4'h5);
        sfr_write(ACC_CTRL_ADDR, 8'h25);
        wait_result(4'h5);
        chk("cont", 16'h1, {15'h0, sfr_rdata[ACC_CONT_BIT]});
        sfr_write(ACC_CTRL_ADDR, 8'h00);
        chk("done sw", 16'h0, {15'h0, sfr_rdata[ACC_DONE_BIT]});
        repeat (120) @(posedge clk);
        ack_pulse();
        // memory-driven sequence; channel bits 7 must be ignored
        wr_log.delete();
        sfr_write(ACC_CTRL_ADDR, 8'h47);
        k = 0;
        for (int n = 0; n < 5000 && sfr_rdata[ACC_DMA_BIT] !== 1'b0; n++) begin
            @(posedge clk);
            #1;
            if (result_valid === 1'b1 && k < 2) begin
                chk("dma channel", 16'(k + 1), {12'h0, mux_channel});
                k++;
            end
        end
        @(posedge clk);
        #1;
        chk("dma bit", 16'h0, {15'h0, sfr_rdata[ACC_DMA_BIT]});
        chk("dma done", 16'h1, {15'h0, sfr_rdata[ACC_DONE_BIT]});
        chk("writes", 16'h2, 16'(wr_log.size()));
        if (wr_log.size() >= 2) begin
            chk("word 0", {4'h1, TARGET}, wr_log[0]);
            chk("word 1", {4'h2, TARGET}, wr_log[1]);
        end
        finish_test();
    end

    // watchdog: the sequence needs well under 30000 cycles
    initial begin
        #600_000;
        err_total++;
        finish_test();
    end
endmodule : acc_top_tb

//--- pkg/acc_pkg.sv
// package: register map, field positions and timing for the conversion control
package acc_pkg;
    localparam logic [7:0] ACC_CTRL_ADDR      = 8'hD8;
    localparam logic [7:0] ACC_CTRL_RESET     = 8'h00;
    localparam int         ACC_DONE_BIT       = 7;
    localparam int         ACC_DMA_BIT        = 6;
    localparam int         ACC_CONT_BIT       = 5;
    localparam int         ACC_SINGLE_BIT     = 4;
    localparam int         ACC_CH_MSB         = 3;
    localparam logic [3:0] ACC_CH_TEMP        = 4'h8;
    localparam logic [3:0] ACC_CH_REF         = 4'hC;
    localparam logic [3:0] ACC_CH_STOP        = 4'hF;
    localparam logic [7:0] ACC_PORT1_RESET    = 8'hFF;
    localparam int         ACC_RES_W          = 12;
    localparam logic [3:0] ACC_SAR_BITS       = 4'hC;
    localparam int         ACC_CLK_MHZ        = 50;
    localparam int         ACC_TEMP_ACQ_NS    = 1000;
    localparam logic [7:0] ACC_TEMP_ACQ_CYC   = 8'(ACC_TEMP_ACQ_NS * ACC_CLK_MHZ / 1000);
    localparam logic [1:0] ACC_PIPE_FILL      = 2'h2;
    typedef enum logic [2:0] {ACC_IDLE, ACC_FETCH, ACC_SAMPLE, ACC_CONVERT, ACC_WRITE} acc_state_t;
endpackage : acc_pkg

//--- rtl/acc_top.sv
// conversion control: mode register, sample/convert sequencer, memory-driven sequence
`timescale 1ns/1ps
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module acc_top import acc_pkg::*; (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // special-function register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [7:0]  port1_wdata,
    input  wire logic        port1_wr,
    output logic      [7:0]  port1_analog_mode,
    input  wire logic        irq_vector_ack,
    // timing configuration
    input  wire logic [7:0]  acq_cycles,
    input  wire logic [7:0]  conv_div,
    // analog front end
    output logic      [3:0]  mux_channel,
    output logic             track,
    output logic      [11:0] cap_dac,
    input  wire logic        comparator_hi,
    output logic      [11:0] result,
    output logic             result_valid,
    // external data memory
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic [15:0] mem_rdata,
    input  wire logic [15:0] dma_base_addr,
    // address-latch strobe gating
    input  wire logic        ale_in,
    output logic             ale_out
);
    // ----------------------------------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic       cmp_s1_q, cmp_s2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];
    // comparator is asynchronous to clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= comparator_hi;
            cmp_s2_q <= cmp_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    acc_state_t  st_q, st_d;
    logic [7:0]  ctrl_q, ctrl_d, p1_q, p1_d, cnt_q, cnt_d, div_q, div_d;
    logic [3:0]  ch_q, ch_d, bit_q, bit_d, wch_q, wch_d;
    logic [11:0] sar_q, sar_d, res_q, res_d;
    logic        rv_q, rv_d, trk_q, trk_d;
    logic        rd_q, rd_d, wr_q, wr_d, ale_q, ale_d;
    logic [15:0] addr_q, addr_d, wd_q, wd_d;
    logic [1:0]  fill_q, fill_d;
    logic        ctrl_wr;
    logic [7:0]  acq_eff;

    assign ctrl_wr = sfr_wr && (sfr_addr == ACC_CTRL_ADDR);
    // the temperature monitor needs its minimum; short settings are stretched
    assign acq_eff = (ch_q == ACC_CH_TEMP && acq_cycles < ACC_TEMP_ACQ_CYC) ?
                     ACC_TEMP_ACQ_CYC : acq_cycles;

    always_comb begin
        st_d = st_q; ctrl_d = ctrl_q; p1_d = p1_q; cnt_d = cnt_q; div_d = div_q;
        ch_d = ch_q; bit_d = bit_q; wch_d = wch_q; sar_d = sar_q; res_d = res_q;
        rv_d = 1'b0; trk_d = trk_q; rd_d = 1'b0; wr_d = 1'b0;
        addr_d = addr_q; wd_d = wd_q; fill_d = fill_q;
        if (port1_wr) begin
            p1_d = port1_wdata;
        end
        if (ctrl_wr) begin
            ctrl_d = sfr_wdata;
        end
        if (irq_vector_ack) begin
            ctrl_d[ACC_DONE_BIT] = 1'b0;
        end
        unique case (st_q)
            ACC_IDLE: begin
                trk_d = 1'b0;
                if (ctrl_d[ACC_DMA_BIT]) begin
                    addr_d = dma_base_addr;
                    fill_d = 2'h0;
                    rd_d   = 1'b1;
                    st_d   = ACC_FETCH;
                end else if (ctrl_d[ACC_SINGLE_BIT] || ctrl_d[ACC_CONT_BIT]) begin
                    ch_d  = ctrl_d[ACC_CH_MSB:0];
                    cnt_d = 8'h0;
                    trk_d = 1'b1;
                    st_d  = ACC_SAMPLE;
                end
            end
            ACC_FETCH: begin
                // identifier read; convert it next, write previous meanwhile
                wch_d = ch_q;
                ch_d  = mem_rdata[15:12];
                if (mem_rdata[15:12] == ACC_CH_STOP) begin
                    ctrl_d[ACC_DMA_BIT]  = 1'b0;
                    ctrl_d[ACC_DONE_BIT] = 1'b1;
                    st_d = ACC_IDLE;
                    // last result has no later cycle to ride in, so flush it here
                    if (fill_q != 2'h0) begin
                        wr_d   = 1'b1;
                        wd_d   = {ch_q, res_q};
                        addr_d = addr_q + 16'h2;
                    end
                end else begin
                    cnt_d = 8'h0;
                    trk_d = 1'b1;
                    st_d  = ACC_SAMPLE;
                end
            end
            ACC_SAMPLE: begin
                cnt_d = cnt_q + 8'h1;
                if (cnt_q >= acq_eff) begin
                    trk_d = 1'b0;
                    sar_d = 12'h800;
                    bit_d = ACC_SAR_BITS - 4'h1;
                    div_d = 8'h0;
                    st_d  = ACC_CONVERT;
                    if (ctrl_q[ACC_DMA_BIT] && fill_q >= ACC_PIPE_FILL - 2'h1) begin
                        wr_d   = 1'b1;
                        wd_d   = {wch_q, res_q};
                        addr_d = addr_q + 16'h2;
                    end
                end
            end
            ACC_CONVERT: begin
                div_d = div_q + 8'h1;
                if (div_q >= conv_div) begin
                    div_d = 8'h0;
                    sar_d = sar_q;
                    if (cmp_s2_q) begin
                        sar_d[bit_q] = 1'b0;
                    end
                    if (bit_q != 4'h0) begin
                        sar_d[bit_q - 4'h1] = 1'b1;
                        bit_d = bit_q - 4'h1;
                    end else begin
                        res_d = sar_d;
                        rv_d  = 1'b1;
                        st_d  = ACC_WRITE;
                    end
                end
            end
            ACC_WRITE: begin
                if (ctrl_q[ACC_DMA_BIT]) begin
                    if (fill_q != 2'h3) begin
                        fill_d = fill_q + 2'h1;
                    end
                    addr_d = addr_q + 16'h2;
                    rd_d   = 1'b1;
                    st_d   = ACC_FETCH;
                end else begin
                    ctrl_d[ACC_SINGLE_BIT] = 1'b0;
                    ctrl_d[ACC_DONE_BIT]   = 1'b1;
                    st_d = ACC_IDLE;
                end
            end
            default: st_d = ACC_IDLE;
        endcase
    end

    // strobe suppressed during the memory-driven sequence
    assign ale_d = ale_in && !ctrl_q[ACC_DMA_BIT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ACC_IDLE;  ctrl_q <= ACC_CTRL_RESET; p1_q <= ACC_PORT1_RESET;
            cnt_q <= 8'h0; div_q <= 8'h0; ch_q <= 4'h0; bit_q <= 4'h0; wch_q <= 4'h0;
            sar_q <= 12'h0; res_q <= 12'h0; rv_q <= 1'b0; trk_q <= 1'b0;
            rd_q <= 1'b0; wr_q <= 1'b0; addr_q <= 16'h0; wd_q <= 16'h0; fill_q <= 2'h0;
            ale_q <= 1'b0;
        end else begin
            st_q <= st_d; ctrl_q <= ctrl_d; p1_q <= p1_d; cnt_q <= cnt_d; div_q <= div_d;
            ch_q <= ch_d; bit_q <= bit_d; wch_q <= wch_d; sar_q <= sar_d; res_q <= res_d;
            rv_q <= rv_d; trk_q <= trk_d; rd_q <= rd_d; wr_q <= wr_d;
            addr_q <= addr_d; wd_q <= wd_d; fill_q <= fill_d; ale_q <= ale_d;
        end
    end

    assign sfr_rdata         = ctrl_q;
    assign port1_analog_mode = p1_q;
    assign mux_channel       = ch_q;
    assign track             = trk_q;
    assign cap_dac           = sar_q;
    assign result            = res_q;
    assign result_valid      = rv_q;
    assign mem_rd            = rd_q;
    assign mem_wr            = wr_q;
    assign mem_addr          = addr_q;
    assign mem_wdata         = wd_q;
    assign ale_out           = ale_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SINGLE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == ACC_WRITE && !ctrl_q[ACC_DMA_BIT] && !irq_vector_ack)
        |=> (!ctrl_q[ACC_SINGLE_BIT] || $past(ctrl_wr)) && ctrl_q[ACC_DONE_BIT])
        else $error("single bit not cleared or flag not set");
    AST_ALE_GATE: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[ACC_DMA_BIT] |=> !ale_out)
        else $error("strobe active during DMA");
    AST_STOP_END: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == ACC_FETCH && mem_rdata[15:12] == ACC_CH_STOP && !ctrl_wr)
        |=> !ctrl_q[ACC_DMA_BIT] && st_q == ACC_IDLE)
        else $error("stop code did not end DMA");
    AST_VEC_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        (irq_vector_ack && st_q != ACC_WRITE && st_q != ACC_FETCH && !ctrl_wr)
        |=> !ctrl_q[ACC_DONE_BIT])
        else $error("vector did not clear flag");
    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == ACC_CONVERT |-> !track)
        else $error("tracking during conversion");
    AST_DMA_CH: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == ACC_FETCH) |=> mux_channel == $past(mem_rdata[15:12]))
        else $error("DMA channel not from memory");
    AST_DONE_SET: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ctrl_q[ACC_DONE_BIT]) |-> $past(st_q) inside {ACC_WRITE, ACC_FETCH}
        || $past(ctrl_wr))
        else $error("flag set without completion");
    AST_TEMP_ACQ: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == ACC_SAMPLE && ch_q == ACC_CH_TEMP && cnt_q < ACC_TEMP_ACQ_CYC)
        |=> track)
        else $error("temperature acquisition too short");
endmodule : acc_top
